//--- dlt_map.svh
// register indices, field positions, reset values and timing counts of the timer block
`ifndef DLT_MAP_SVH
`define DLT_MAP_SVH

// register indices; byte address is four times the index
`define DLT_T0_CNT_IDX   7'h50
`define DLT_T0_LIMA_IDX  7'h52
`define DLT_T0_LIMB_IDX  7'h54
`define DLT_T0_CTL_IDX   7'h56
`define DLT_T1_CNT_IDX   7'h58
`define DLT_T1_LIMA_IDX  7'h5A
`define DLT_T1_LIMB_IDX  7'h5C
`define DLT_T1_CTL_IDX   7'h5E
`define DLT_T2_CNT_IDX   7'h60
`define DLT_T2_LIMA_IDX  7'h62
`define DLT_T2_CTL_IDX   7'h66

// mode/control word field positions
`define DLT_CTL_RUN      15
`define DLT_CTL_WMASK    14
`define DLT_CTL_IRQEN    13
`define DLT_CTL_INUSE    12
`define DLT_CTL_TCF      5
`define DLT_CTL_RETRIG   4
`define DLT_CTL_PRE      3
`define DLT_CTL_OUTCLK   2
`define DLT_CTL_DUAL     1
`define DLT_CTL_FREE     0

// low mode field width and the bits that survive on the third timer
`define DLT_MODE_W       5
`define DLT_T2_MODE_MASK 5'h01

// reset values
`define DLT_CNT_RST      16'h0000
`define DLT_LIM_RST      16'h0000
`define DLT_MODE_RST     5'h00

// internal clock runs the timers at one event every four system clocks
`define DLT_TICK_DIV     2'h3

`endif

//--- dlt_pkg.sv
// types shared by the timer block
package dlt_pkg;

  typedef logic [15:0] dlt_word_t;

  // which register of a timer an access addresses
  typedef enum logic [2:0] {
    DLT_REG_CNT,
    DLT_REG_LIMA,
    DLT_REG_LIMB,
    DLT_REG_CTL,
    DLT_REG_NONE
  } dlt_reg_t;

endpackage

//--- dlt_event_gen.sv
// per-timer count event and restart generation from tick, pin and prescale source
`timescale 1ns/100ps
module dlt_event_gen (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic tick,
  input  wire logic pin_in,
  input  wire logic outside_clock_sel,
  input  wire logic pre_sel,
  input  wire logic retrigger_sel,
  input  wire logic run,
  input  wire logic pre_evt,
  output logic      evt,
  output logic      restart
);

  logic pin_d_r;
  logic armed_r;
  logic pin_rise;
  logic base_evt;

  ////////////////////////////////////////////////////////////////////////////
  // pin edge history; pins are already synchronous to sys_clk
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= pin_in;
    end
  end

  assign pin_rise = pin_in & ~pin_d_r;

  // retrigger mode waits for a first rising edge before counting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
    end else if (!run || !retrigger_sel) begin
      armed_r <= 1'b0;   // edges while halted are ignored
    end else if (pin_rise) begin
      armed_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event selection: outside edges, prescaled source, or gated/armed tick
  always_comb begin
    base_evt = pre_sel ? pre_evt : tick;
    if (!run) begin
      evt     = 1'b0;
      restart = 1'b0;
    end else if (outside_clock_sel) begin
      evt     = pin_rise;
      restart = 1'b0;
    end else if (retrigger_sel) begin
      evt     = base_evt & armed_r;
      restart = pin_rise;   // each rising edge clears the count
    end else begin
      evt     = base_evt & pin_in;   // level gates the count
      restart = 1'b0;
    end
  end

endmodule

//--- dlt_timer.sv
// three 16-bit limit timers with an APB register slave
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "dlt_map.svh"
module dlt_timer (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  tmr_in,
  output logic      [1:0]  tmr_out,
  output logic      [2:0]  tmr_irq
);

  localparam int NTMR = 3;

  // per-timer register indices
  localparam logic [6:0] CNT_IDX [NTMR] = '{`DLT_T0_CNT_IDX, `DLT_T1_CNT_IDX,
                                             `DLT_T2_CNT_IDX};
  localparam logic [6:0] LIMA_IDX[NTMR] = '{`DLT_T0_LIMA_IDX, `DLT_T1_LIMA_IDX,
                                             `DLT_T2_LIMA_IDX};
  localparam logic [6:0] LIMB_IDX[2]    = '{`DLT_T0_LIMB_IDX, `DLT_T1_LIMB_IDX};
  localparam logic [6:0] CTL_IDX [NTMR] = '{`DLT_T0_CTL_IDX, `DLT_T1_CTL_IDX,
                                             `DLT_T2_CTL_IDX};

  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [1:0]       tmr_out_r;
  logic [2:0]       tmr_irq_r;
  logic [1:0]       tick_cnt_r;
  logic             tick;
  logic [6:0]       idx;
  logic             addr_ok;
  logic             apb_wr;
  dlt_pkg::dlt_reg_t sel_reg;
  logic [1:0]       sel_tmr;
  logic [15:0]      rd_word;
  logic [15:0]      wdat;

  dlt_pkg::dlt_word_t cnt_r  [NTMR];
  dlt_pkg::dlt_word_t lima_r [NTMR];
  dlt_pkg::dlt_word_t limb   [NTMR];
  dlt_pkg::dlt_word_t ctl_rd [NTMR];
  logic [NTMR-1:0]    term;
  logic [NTMR-1:0]    dual_on;
  logic [NTMR-1:0]    in_use_q;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign tmr_out = tmr_out_r;
  assign tmr_irq = tmr_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // shared quarter-rate tick for internally clocked timers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 2'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 2'h1;
    end
  end

  assign tick = (tick_cnt_r == `DLT_TICK_DIV);

  ////////////////////////////////////////////////////////////////////////////
  // address decode: word index, timer and register selected
  assign idx     = paddr[8:2];
  assign addr_ok = (paddr[31:9] == 23'h000000) && (paddr[1:0] == 2'h0);
  assign wdat    = pwdata[15:0];

  always_comb begin
    sel_reg = dlt_pkg::DLT_REG_NONE;
    sel_tmr = 2'h0;
    for (int t = 0; t < NTMR; t++) begin
      if (addr_ok && idx == CNT_IDX[t]) begin
        sel_reg = dlt_pkg::DLT_REG_CNT;
        sel_tmr = 2'(t);
      end
      if (addr_ok && idx == LIMA_IDX[t]) begin
        sel_reg = dlt_pkg::DLT_REG_LIMA;
        sel_tmr = 2'(t);
      end
      if (addr_ok && idx == CTL_IDX[t]) begin
        sel_reg = dlt_pkg::DLT_REG_CTL;
        sel_tmr = 2'(t);
      end
    end
    // only the first two timers carry a second limit
    for (int t = 0; t < 2; t++) begin
      if (addr_ok && idx == LIMB_IDX[t]) begin
        sel_reg = dlt_pkg::DLT_REG_LIMB;
        sel_tmr = 2'(t);
      end
    end
  end

  // read mux over the selected timer
  always_comb begin
    case (sel_reg)
      dlt_pkg::DLT_REG_CNT:  rd_word = cnt_r[sel_tmr];
      dlt_pkg::DLT_REG_LIMA: rd_word = lima_r[sel_tmr];
      dlt_pkg::DLT_REG_LIMB: rd_word = limb[sel_tmr];
      dlt_pkg::DLT_REG_CTL:  rd_word = ctl_rd[sel_tmr];
      default:               rd_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: answer prepared in setup, so access completes in one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else if (psel && !penable) begin
      pready_r  <= 1'b1;
      pslverr_r <= (sel_reg == dlt_pkg::DLT_REG_NONE);
      prdata_r  <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // a write lands only at the completing access edge
  assign apb_wr = psel && penable && pready_r && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // per-timer counting, limits and mode/control word
  for (genvar gi = 0; gi < NTMR; gi++) begin : g_tmr
    logic [`DLT_MODE_W-1:0] mode_r;
    logic [`DLT_MODE_W-1:0] mode_mask;
    logic                   run_r;
    logic                   irqen_r;
    logic                   in_use_r;
    logic                   tcf_r;
    logic                   evt;
    logic                   restart;
    logic                   pin;
    logic [15:0]            inc;
    logic [15:0]            act_lim;
    logic                   wr_cnt;
    logic                   wr_lima;
    logic                   wr_ctl;
    logic                   stop;

    // third timer keeps only its free-run bit
    assign mode_mask = (gi == 2) ? `DLT_T2_MODE_MASK : {`DLT_MODE_W{1'b1}};
    assign pin       = (gi < 2) ? tmr_in[gi] : 1'b1;   // no pin on timer 2: gate open

    assign wr_cnt  = apb_wr && sel_tmr == 2'(gi) && sel_reg == dlt_pkg::DLT_REG_CNT;
    assign wr_lima = apb_wr && sel_tmr == 2'(gi) && sel_reg == dlt_pkg::DLT_REG_LIMA;
    assign wr_ctl  = apb_wr && sel_tmr == 2'(gi) && sel_reg == dlt_pkg::DLT_REG_CTL;

    // timer 2 never prescales itself, so its own terminal stays off its input
    dlt_event_gen u_evt (
      .sys_clk           (sys_clk),
      .nrst              (nrst),
      .tick              (tick),
      .pin_in            (pin),
      .outside_clock_sel (mode_r[`DLT_CTL_OUTCLK]),
      .pre_sel           (mode_r[`DLT_CTL_PRE]),
      .retrigger_sel     (mode_r[`DLT_CTL_RETRIG]),
      .run               (run_r),
      .pre_evt           ((gi < 2) ? term[2] : 1'b0),
      .evt               (evt),
      .restart           (restart)
    );

    // compare against B only while alternating and B is in use
    assign dual_on[gi]  = mode_r[`DLT_CTL_DUAL];
    assign in_use_q[gi] = in_use_r;
    assign act_lim      = (dual_on[gi] && in_use_r) ? limb[gi] : lima_r[gi];
    assign inc        = cnt_r[gi] + 16'h0001;
    // equality only: a count above the limit runs on through the wrap
    assign term[gi]   = evt && !restart && (inc == act_lim);
    // one-shot halts at A without alternation, or after B with it
    assign stop       = term[gi] && !mode_r[`DLT_CTL_FREE] &&
                        (!dual_on[gi] || in_use_r);

    // count register: software write overrides the event this cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        cnt_r[gi] <= `DLT_CNT_RST;
      end else if (wr_cnt) begin
        cnt_r[gi] <= wdat;
      end else if (restart) begin
        cnt_r[gi] <= 16'h0000;
      end else if (evt) begin
        cnt_r[gi] <= term[gi] ? 16'h0000 : inc;
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        lima_r[gi] <= `DLT_LIM_RST;
      end else if (wr_lima) begin
        lima_r[gi] <= wdat;
      end
    end

    if (gi < 2) begin : g_limb
      logic [15:0] limb_r;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          limb_r <= `DLT_LIM_RST;
        end else if (apb_wr && sel_tmr == 2'(gi) && sel_reg == dlt_pkg::DLT_REG_LIMB) begin
          limb_r <= wdat;
        end
      end
      assign limb[gi] = limb_r;
    end else begin : g_nolimb
      assign limb[gi] = 16'h0000;
    end

    // low mode bits, masked on the third timer
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        mode_r <= `DLT_MODE_RST;
      end else if (wr_ctl) begin
        mode_r <= wdat[`DLT_MODE_W-1:0] & mode_mask;
      end
    end

    // run bit: only a masked write or a one-shot stop touches it
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        run_r <= 1'b0;
      end else if (wr_ctl && wdat[`DLT_CTL_WMASK]) begin
        run_r <= wdat[`DLT_CTL_RUN];
      end else if (stop) begin
        run_r <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        irqen_r <= 1'b0;
      end else if (wr_ctl) begin
        irqen_r <= wdat[`DLT_CTL_IRQEN];
      end
    end

    // in-use bit: hardware only, cleared whenever alternation is off
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        in_use_r <= 1'b0;
      end else if (!dual_on[gi]) begin
        in_use_r <= 1'b0;
      end else if (term[gi]) begin
        in_use_r <= ~in_use_r;
      end
    end

    // sticky flag; a terminal count in the clearing cycle still sets it
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        tcf_r <= 1'b0;
      end else if (term[gi]) begin
        tcf_r <= 1'b1;
      end else if (wr_ctl) begin
        tcf_r <= wdat[`DLT_CTL_TCF];
      end
    end

    // request pulse per terminal count; the controller latches it
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        tmr_irq_r[gi] <= 1'b0;
      end else begin
        tmr_irq_r[gi] <= term[gi] && irqen_r;
      end
    end

    // read view; mask bit position always zero
    assign ctl_rd[gi] = {run_r, 1'b0, irqen_r, in_use_r & dual_on[gi],
                         6'h00, tcf_r, mode_r};
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins: one-clock low after terminal, or limit in use when alternating
  for (genvar gp = 0; gp < 2; gp++) begin : g_pin
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        tmr_out_r[gp] <= 1'b1;
      end else if (dual_on[gp]) begin
        tmr_out_r[gp] <= ~in_use_q[gp];
      end else begin
        tmr_out_r[gp] <= ~term[gp];
      end
    end
  end

endmodule

//--- dlt_timer_chk.sv
// assertion checker on the timer block ports
`timescale 1ns/100ps
`include "dlt_map.svh"
module dlt_timer_chk (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  tmr_in,
  input wire logic [1:0]  tmr_out,
  input wire logic [2:0]  tmr_irq
);
  logic [6:0] idx;
  logic       rd_ok;
  logic       ctl_rd;
  // decode what a completing read looked at
  assign idx = paddr[8:2];
  assign rd_ok = pready && !pwrite;
  assign ctl_rd = rd_ok && (idx == `DLT_T0_CTL_IDX || idx == `DLT_T1_CTL_IDX);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_quiet3;
    !tmr_irq[0] [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_ready_once: assert property (pready |-> s_access ##1 !pready)
    else $error("ready outside a single access cycle");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_mask_reads0: assert property (ctl_rd |-> !prdata[14])
    else $error("write mask bit read back as one");
  a_inuse_single: assert property (ctl_rd && !prdata[1] |-> !prdata[12])
    else $error("in-use bit set with dual limit off");
  a_t2_fixed: assert property (rd_ok && idx == `DLT_T2_CTL_IDX
    |-> prdata[12] == 1'b0 && prdata[4:1] == 4'h0)
    else $error("timer 2 hardwired bits not zero");
  a_no_limb_t2: assert property (pready && idx == 7'h64 |-> pslverr && prdata == 32'h0)
    else $error("absent limit register was answered");
  a_irq_pulse: assert property (tmr_irq[0] |=> s_quiet3)
    else $error("interrupt pulse too long or too close");
  a_reset_state: assert property ($rose(nrst) |-> tmr_out == 2'h3 && tmr_irq == 3'h0)
    else $error("pins not idle after reset");
endmodule

//--- dlt_pin_partner.sv
// pin-side partner: drives the timer input pins, watches output 0
`timescale 1ns/100ps
module dlt_pin_partner (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] gate,
  input  wire logic [1:0] tmr_out,
  output logic      [1:0] tmr_in,
  output logic      [7:0] low_cnt
);
  ////////////////////////////////////////////////////////////////////
  // gate level reaches the pin a clock later, like a sync stage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_in <= 2'h0;
    end else begin
      tmr_in <= gate;
    end
  end
  // low cycles on output 0 tell a pulse from a stuck level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 8'h00;
    end else if (!tmr_out[0]) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
endmodule

//--- tb_dual_limit_timer_control.sv
// self-checking bench for the three-timer block
`timescale 1ns/100ps
`include "dlt_map.svh"
module tb_dual_limit_timer_control;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  gate    = 2'h0;
  logic [1:0]  tmr_in;
  logic [1:0]  tmr_out;
  logic [2:0]  tmr_irq;
  logic [7:0]  low_cnt;
  int          err_total = 0;
  int          samples_checked = 0;
  localparam logic [31:0] RUN = 32'h8000, MSK = 32'h4000, IEN = 32'h2000;
  localparam logic [31:0] INUSE = 32'h1000, TCF = 32'h20, DUAL = 32'h2, FRE = 32'h1;
  localparam logic [31:0] OUTCLK = 32'h4;
  logic [6:0] idxs [11] = '{`DLT_T0_CNT_IDX, `DLT_T0_LIMA_IDX, `DLT_T0_LIMB_IDX,
    `DLT_T0_CTL_IDX, `DLT_T1_CNT_IDX, `DLT_T1_LIMA_IDX, `DLT_T1_LIMB_IDX,
    `DLT_T1_CTL_IDX, `DLT_T2_CNT_IDX, `DLT_T2_LIMA_IDX, `DLT_T2_CTL_IDX};
  always #2.5 sys_clk = ~sys_clk;
  dlt_timer dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr_in(tmr_in), .tmr_out(tmr_out), .tmr_irq(tmr_irq));
  dlt_pin_partner pins (.sys_clk(sys_clk), .nrst(nrst), .gate(gate), .tmr_out(tmr_out),
    .tmr_in(tmr_in), .low_cnt(low_cnt));
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [6:0] i, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {23'h0, i, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, i, d, q, e);
  endtask
  task automatic rd(input logic [6:0] i, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, i, 32'h0, q, e);
    chk(q, exp);
  endtask
  // bounded wait for an interrupt pulse of timer i
  task automatic wait_irq(input int i, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tmr_irq[i] !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_total++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    chk({30'h0, tmr_out}, 32'h3);
    foreach (idxs[k]) rd(idxs[k], 32'h0);
    apb(1'b0, 7'h64, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    // run bit moves only with the mask; mask itself never stored
    wr(`DLT_T0_LIMA_IDX, 32'h3);
    wr(`DLT_T0_CTL_IDX, RUN | FRE);
    rd(`DLT_T0_CTL_IDX, FRE);
    wr(`DLT_T0_CTL_IDX, RUN | MSK | IEN | FRE);
    rd(`DLT_T0_CTL_IDX, RUN | IEN | FRE);
    gate[0] <= 1'b1;
    wait_irq(0, n);
    chk({31'h0, tmr_out[0]}, 32'h0);
    gate[0] <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rd(`DLT_T0_CTL_IDX, RUN | IEN | TCF | FRE);
    chk({24'h0, low_cnt}, 32'h1);
    wr(`DLT_T0_CTL_IDX, IEN | FRE);
    rd(`DLT_T0_CTL_IDX, RUN | IEN | FRE);
    // halting timer without interrupt still flags terminal count
    wr(`DLT_T0_CTL_IDX, RUN | MSK);
    gate[0] <= 1'b1;
    n = 0;
    // count every cycle a request shows, not just the last one
    repeat (40) begin
      @(posedge sys_clk);
      if (tmr_irq[0] !== 1'b0) n++;
    end
    gate[0] <= 1'b0;
    chk(n, 32'h0);
    chk({29'h0, tmr_irq}, 32'h0);
    chk({24'h0, low_cnt}, 32'h2);
    rd(`DLT_T0_CTL_IDX, TCF);
    // outside clock: each rising pin edge is one count, tick ignored
    wr(`DLT_T0_CTL_IDX, RUN | MSK | OUTCLK | FRE);
    for (int k = 0; k < 3; k++) begin
      gate[0] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      gate[0] <= 1'b0;
      repeat (3) @(posedge sys_clk);
      if (k == 1) rd(`DLT_T0_CNT_IDX, 32'h2);
    end
    rd(`DLT_T0_CTL_IDX, RUN | TCF | OUTCLK | FRE);
    rd(`DLT_T0_CNT_IDX, 32'h0);
    // alternating limits on timer 1; in-use bit is read-only
    wr(`DLT_T1_LIMA_IDX, 32'h2);
    wr(`DLT_T1_LIMB_IDX, 32'h3);
    wr(`DLT_T1_CTL_IDX, RUN | MSK | IEN | DUAL | FRE);
    gate[1] <= 1'b1;
    wait_irq(1, n);
    rd(`DLT_T1_CTL_IDX, RUN | IEN | INUSE | TCF | DUAL | FRE);
    chk({31'h0, tmr_out[1]}, 32'h0);
    wait_irq(1, n);
    gate[1] <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, tmr_out[1]}, 32'h1);
    wr(`DLT_T1_CTL_IDX, IEN | INUSE | DUAL | FRE);
    rd(`DLT_T1_CTL_IDX, RUN | IEN | DUAL | FRE);
    // count above limit must wrap through zero first
    wr(`DLT_T2_LIMA_IDX, 32'h2);
    wr(`DLT_T2_CNT_IDX, 32'hFFFE);
    wr(`DLT_T2_CTL_IDX, 32'hE01F);
    wait_irq(2, n);
    chk({31'h0, n >= 12}, 32'h1);
    rd(`DLT_T2_CTL_IDX, 32'hA021);
    complete_run();
  end
endmodule
bind dlt_timer dlt_timer_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tmr_in(tmr_in), .tmr_out(tmr_out),
  .tmr_irq(tmr_irq));
